// File: inc/uart_rx_pkg.sv
// Constants for the receive status and data readout block.
// Assumes a 32-bit AHB-Lite slave with one aligned word per register.
package uart_rx_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_STATUS  = 8'h00;
  localparam logic [7:0] OFS_RXDATA  = 8'h04;
  localparam logic [7:0] OFS_CONFIG  = 8'h08;
  localparam logic [7:0] OFS_BAUD    = 8'h0C;
  localparam logic [7:0] OFS_IRQ_ST  = 8'h10;
  localparam logic [7:0] OFS_IRQ_MSK = 8'h14;

  // Status field positions
  localparam int ST_AVAIL_BIT = 0;
  localparam int ST_OVR_BIT   = 1;
  localparam int ST_FRAMING_ERROR_FLAG_BIT  = 2;
  localparam int ST_PARITY_ERROR_FLAG_BIT  = 3;
  localparam int ST_IDLE_BIT  = 4;

  // Config field positions and parity codes
  localparam int CFG_EN_BIT   = 0;
  localparam int CFG_NINE_BIT = 1;
  localparam int CFG_PAR_LSB  = 2;
  localparam int CFG_W        = 4;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ODD  = 2'h2;

  // Interrupt event positions
  localparam int EV_RX   = 0;
  localparam int EV_PARITY_ERROR_FLAG = 1;
  localparam int EV_FRAMING_ERROR_FLAG = 2;
  localparam int EV_OVR  = 3;
  localparam int EV_W    = 4;

  // Stored character layout
  localparam int CHR_W     = 11;
  localparam int CHR_PARITY_ERROR_FLAG  = 9;
  localparam int CHR_FRAMING_ERROR_FLAG  = 10;

  // Reset values
  localparam logic [CFG_W-1:0] CONFIG_RST  = 4'h0;
  localparam logic [15:0]      BAUD_RST    = 16'h0000;
  localparam logic [EV_W-1:0]  IRQ_MSK_RST = 4'h0;

  // Oversampling timing, in baud ticks
  localparam logic [3:0] PHASE_MID  = 4'h7;
  localparam logic [3:0] PHASE_LAST = 4'hF;

  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PARITY, ST_STOP} rx_state_t;

endpackage

// File: inc/rx_fifo_if.sv
// Link between the receiver control logic and its character store.
// Assumes one clock shared by both ends.
`timescale 1ns/10ps
interface rx_fifo_if #(parameter int WIDTH = 11);
  logic             push;
  logic [WIDTH-1:0] wdata;
  logic             pop;
  logic             flush;
  logic             full;
  logic             avail;
  logic [WIDTH-1:0] head;

  modport producer (output push, output wdata, output pop, output flush,
                    input full, input avail, input head);
  modport store    (input push, input wdata, input pop, input flush,
                    output full, output avail, output head);
endinterface

// File: core/rx_bit_sync.sv
// Two-stage synchroniser for a level arriving from outside the clock domain.
// Assumes the input is asynchronous to clk.
`timescale 1ns/10ps
module rx_bit_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic din,
  output logic      dout
);
  logic meta_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= RESET_VAL;
      dout     <= RESET_VAL;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end
endmodule

// File: core/rx_char_store.sv
// Receive character buffer; head of queue comes out of a register.
// Assumes push is never given while full and pop never while empty.
`timescale 1ns/10ps
module rx_char_store #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 4
) (
  input  wire logic clk,
  input  wire logic rst_n,
  rx_fifo_if.store  port
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST_IDX = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW-1:0]    wr_ptr_reg;
  logic [CW-1:0]    count_reg;
  logic [WIDTH-1:0] head_reg;
  logic             avail_reg;
  wire  [PW-1:0]    rd_ptr_inc = (rd_ptr_reg == LAST_IDX) ? '0 : rd_ptr_reg + 1'b1;
  wire  [PW-1:0]    wr_ptr_inc = (wr_ptr_reg == LAST_IDX) ? '0 : wr_ptr_reg + 1'b1;
  wire  [PW-1:0]    rd_ptr_next = port.pop ? rd_ptr_inc : rd_ptr_reg;
  wire  [CW-1:0]    count_next = count_reg + CW'(port.push) - CW'(port.pop);
  // A write into an empty slot at the new head must bypass the array
  wire              bypass = port.push && (count_reg == CW'(port.pop));

  assign port.full  = (count_reg == CW'(DEPTH));
  assign port.avail = avail_reg;
  assign port.head  = head_reg;

  always_ff @(posedge clk) begin
    if (port.push) begin
      mem[wr_ptr_reg] <= port.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ptr_reg <= '0;
      wr_ptr_reg <= '0;
      count_reg  <= '0;
      head_reg   <= '0;
      avail_reg  <= 1'b0;
    end else if (port.flush) begin
      rd_ptr_reg <= '0;
      wr_ptr_reg <= '0;
      count_reg  <= '0;
      head_reg   <= '0;
      avail_reg  <= 1'b0;
    end else begin
      rd_ptr_reg <= rd_ptr_next;
      wr_ptr_reg <= port.push ? wr_ptr_inc : wr_ptr_reg;
      count_reg  <= count_next;
      head_reg   <= bypass ? port.wdata : mem[rd_ptr_next];
      avail_reg  <= (count_next != '0);
    end
  end
endmodule

// File: core/uart_rx_status.sv
// Receive side of an asynchronous serial port: deserialiser, character
// buffer, receive status flags, data readout and interrupt, on AHB-Lite.
// Assumes a single AHB-Lite master and the rx line idling high.
//
// Design decisions made here: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps

// Notes on behaviour
// - Status bit 4 reads 1 while no character is being received and 0 during reception, and ignores writes.
// - Status bit 3 shows a parity mismatch of the head character and reads 0 otherwise.
// - Status bit 2 shows an invalid stop bit of the head character and reads 0 otherwise.
// - Status bit 1 is set when a character completes while the receive buffer is full.
// - Software can only clear the overrun flag, and clearing it empties the buffer and the shift register.
// - Only the overrun bit of the status group takes a software write, and only as a clear.
// - Status bit 0 reads 1 while at least one unread character is buffered and 0 when empty.
module uart_rx_status
  import uart_rx_pkg::*;
#(
  parameter int RX_DEPTH = 4
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        rx_pin,
  output logic             irq
);

  rx_fifo_if #(.WIDTH(CHR_W)) fifo ();

  // Line input
  logic rx_line;

  rx_bit_sync #(
    .RESET_VAL (1'b1)
  ) u_rx_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .din   (rx_pin),
    .dout  (rx_line)
  );

  rx_char_store #(
    .WIDTH (CHR_W),
    .DEPTH (RX_DEPTH)
  ) u_store (
    .clk   (hclk),
    .rst_n (hresetn),
    .port  (fifo.store)
  );

  // Bus-side state
  logic             dp_write_reg;
  logic             dp_read_reg;
  logic [7:0]       dp_addr_reg;
  logic [31:0]      hrdata_reg;
  logic             hreadyout_reg;
  logic             hresp_reg;
  logic             irq_reg;

  // Software registers
  logic [CFG_W-1:0] config_reg;
  logic [15:0]      baud_div_reg;
  logic [EV_W-1:0]  irq_stat_reg;
  logic [EV_W-1:0]  irq_stat_next;
  logic [EV_W-1:0]  irq_mask_reg;
  logic             overrun_error_flag_reg;
  logic             overrun_error_flag_next;

  // Receiver state
  rx_state_t        state_reg;
  rx_state_t        state_next;
  logic [15:0]      tick_cnt_reg;
  logic [3:0]       phase_reg;
  logic [3:0]       phase_next;
  logic [3:0]       bit_idx_reg;
  logic [3:0]       bit_idx_next;
  logic [8:0]       rx_shift_register_reg;
  logic [8:0]       rx_shift_register_next;
  logic             parity_error_flag_reg;
  logic             parity_error_flag_next;
  logic             char_done;

  // Address phase capture and register decode
  wire        addr_take  = hsel && htrans[1] && hready;
  wire        hit_status = (dp_addr_reg == OFS_STATUS);
  wire        hit_rxdata = (dp_addr_reg == OFS_RXDATA);
  wire        hit_config = (dp_addr_reg == OFS_CONFIG);
  wire        hit_baud   = (dp_addr_reg == OFS_BAUD);
  wire        hit_irq_st = (dp_addr_reg == OFS_IRQ_ST);
  wire        hit_irq_mk = (dp_addr_reg == OFS_IRQ_MSK);
  wire        wr_status  = dp_write_reg && hit_status;
  wire        wr_config  = dp_write_reg && hit_config;
  wire        wr_baud    = dp_write_reg && hit_baud;
  wire        wr_irq_st  = dp_write_reg && hit_irq_st;
  wire        wr_irq_mk  = dp_write_reg && hit_irq_mk;

  // Configuration fields
  wire        rx_enable  = config_reg[CFG_EN_BIT];
  wire        nine_bit   = config_reg[CFG_NINE_BIT];
  wire [1:0]  par_mode   = config_reg[CFG_PAR_LSB +: 2];
  wire        par_used   = (par_mode != PAR_NONE) && !nine_bit;
  wire        par_odd    = (par_mode == PAR_ODD);
  wire [3:0]  last_bit   = nine_bit ? 4'h8 : 4'h7;

  // Baud tick at sixteen times the bit rate
  wire        tick       = (tick_cnt_reg == baud_div_reg);
  wire        at_mid     = tick && (phase_reg == PHASE_MID);
  wire        at_last    = tick && (phase_reg == PHASE_LAST);
  wire [3:0]  phase_inc  = tick ? phase_reg + 4'h1 : phase_reg;

  // Head character fields
  wire        head_avail = fifo.avail;
  wire        head_parity_error_flag  = head_avail && fifo.head[CHR_PARITY_ERROR_FLAG];
  wire        head_framing_error_flag  = head_avail && fifo.head[CHR_FRAMING_ERROR_FLAG];
  wire        receiver_idle_flag = (state_reg == ST_IDLE);

  // Overrun handling
  wire        ovr_set    = char_done && fifo.full;
  // Writing zero to a set overrun bit is the only accepted status write
  wire        ovr_clr    = wr_status && !hwdata[ST_OVR_BIT] && overrun_error_flag_reg;
  wire        rx_flush   = ovr_clr && !ovr_set;
  wire        push_ok    = char_done && !fifo.full && !overrun_error_flag_reg;
  wire        frame_bad  = !rx_line;

  // Readout path
  wire        rd_cycle   = dp_read_reg;
  wire        pop_now    = rd_cycle && hit_rxdata && head_avail;

  wire [15:0] status_word = {11'h000,
                             receiver_idle_flag,
                             head_parity_error_flag,
                             head_framing_error_flag,
                             overrun_error_flag_reg,
                             head_avail};
  wire [15:0] rxdata_word = head_avail ? {7'h00, fifo.head[8:0]} : 16'h0000;
  wire [31:0] read_word   = hit_status ? {16'h0000, status_word} :
                            hit_rxdata ? {16'h0000, rxdata_word} :
                            hit_config ? {28'h0000000, config_reg} :
                            hit_baud   ? {16'h0000, baud_div_reg} :
                            hit_irq_st ? {28'h0000000, irq_stat_reg} :
                            hit_irq_mk ? {28'h0000000, irq_mask_reg} :
                            32'h00000000;

  // Interrupt events
  wire [EV_W-1:0] events;
  assign events[EV_RX]   = push_ok;
  assign events[EV_PARITY_ERROR_FLAG] = push_ok && parity_error_flag_reg;
  assign events[EV_FRAMING_ERROR_FLAG] = push_ok && frame_bad;
  assign events[EV_OVR]  = ovr_set && !overrun_error_flag_reg;

  assign fifo.push  = push_ok;
  assign fifo.wdata = {frame_bad, parity_error_flag_reg, rx_shift_register_reg};
  assign fifo.pop   = pop_now;
  assign fifo.flush = rx_flush;

  assign hrdata    = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp     = hresp_reg;
  assign irq       = irq_reg;

  // Sticky flags: a new event wins over a clear in the same cycle
  assign overrun_error_flag_next = ovr_set ? 1'b1 : (ovr_clr ? 1'b0 : overrun_error_flag_reg);
  assign irq_stat_next = (irq_stat_reg & ~(wr_irq_st ? hwdata[EV_W-1:0] : '0)) | events;

  // Deserialiser
  always_comb begin
    state_next             = state_reg;
    phase_next             = phase_inc;
    bit_idx_next           = bit_idx_reg;
    rx_shift_register_next = rx_shift_register_reg;
    parity_error_flag_next              = parity_error_flag_reg;
    char_done              = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        phase_next = 4'h0;
        if (rx_enable && !rx_line) begin
          state_next = ST_START;
        end
      end
      ST_START: begin
        if (at_mid) begin
          phase_next = 4'h0;
          if (rx_line) begin
            // Glitch shorter than half a bit is not a start bit
            state_next = ST_IDLE;
          end else begin
            state_next             = ST_DATA;
            bit_idx_next           = 4'h0;
            rx_shift_register_next = 9'h000;
            parity_error_flag_next              = 1'b0;
          end
        end
      end
      ST_DATA: begin
        if (at_last) begin
          rx_shift_register_next[bit_idx_reg] = rx_line;
          bit_idx_next = bit_idx_reg + 4'h1;
          if (bit_idx_reg == last_bit) begin
            state_next = par_used ? ST_PARITY : ST_STOP;
          end
        end
      end
      ST_PARITY: begin
        if (at_last) begin
          parity_error_flag_next  = (^rx_shift_register_reg[7:0]) ^ rx_line ^ par_odd;
          state_next = ST_STOP;
        end
      end
      ST_STOP: begin
        if (at_last) begin
          char_done  = 1'b1;
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (rx_flush || !rx_enable) begin
      state_next             = ST_IDLE;
      rx_shift_register_next = 9'h000;
      parity_error_flag_next              = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg   <= ST_IDLE;
      phase_reg   <= 4'h0;
      bit_idx_reg <= 4'h0;
    end else begin
      state_reg   <= state_next;
      phase_reg   <= phase_next;
      bit_idx_reg <= bit_idx_next;
    end
  end

  // Shift register and parity result are emptied together on a flush
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_shift_register_reg <= 9'h000;
      parity_error_flag_reg              <= 1'b0;
    end else begin
      rx_shift_register_reg <= rx_shift_register_next;
      parity_error_flag_reg              <= parity_error_flag_next;
    end
  end

  // Free-running divider; start edges align to it within one tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_reg <= 16'h0000;
    end else begin
      tick_cnt_reg <= tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
    end
  end

  // Bus data phase tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write_reg <= 1'b0;
      dp_read_reg  <= 1'b0;
      dp_addr_reg  <= 8'h00;
    end else begin
      dp_write_reg <= addr_take && hwrite;
      dp_read_reg  <= addr_take && !hwrite;
      dp_addr_reg  <= addr_take ? haddr[7:0] : dp_addr_reg;
    end
  end

  // Reads take one wait state so the popped head is registered first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_reg <= 1'b1;
      hresp_reg     <= 1'b0;
    end else begin
      hreadyout_reg <= !(addr_take && !hwrite);
      hresp_reg     <= 1'b0;
    end
  end

  // Read data sampled in the wait state, after any earlier write landed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h00000000;
    end else if (rd_cycle) begin
      hrdata_reg <= read_word;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      config_reg <= CONFIG_RST;
    end else begin
      config_reg <= wr_config ? hwdata[CFG_W-1:0] : config_reg;
    end
  end

  // A divisor lowered below the running count wraps once before it applies
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      baud_div_reg <= BAUD_RST;
    end else begin
      baud_div_reg <= wr_baud ? hwdata[15:0] : baud_div_reg;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask_reg <= IRQ_MSK_RST;
    end else begin
      irq_mask_reg <= wr_irq_mk ? hwdata[EV_W-1:0] : irq_mask_reg;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overrun_error_flag_reg <= 1'b0;
    end else begin
      overrun_error_flag_reg <= overrun_error_flag_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_reg <= '0;
    end else begin
      irq_stat_reg <= irq_stat_next;
    end
  end

  // Registered so the pin cannot glitch while status and mask change
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_stat_reg & irq_mask_reg);
    end
  end

endmodule

// File: verification/uart_rx_status_asserts.sv
// Checker for the receive readout block, watching only its top-level ports.
// Assumes hready is tied to hreadyout and one read completes before the next.
`timescale 1ns/10ps
module uart_rx_status_asserts
  import uart_rx_pkg::*;
#(
  parameter int RX_DEPTH = 4
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        rx_pin,
  input wire logic        irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic       ho_q;
  logic       wr_pend;
  logic       ovr_seen;
  logic [7:0] ofs_q;
  wire        take    = hsel & htrans[1] & hready;
  // Read data is valid in the cycle after the single wait state ends
  wire        rd_end  = hreadyout & ~ho_q;
  wire        st_rd   = rd_end & (ofs_q == OFS_STATUS);
  wire        dat_rd  = rd_end & (ofs_q == OFS_RXDATA);
  wire        ovr_clr = wr_pend & (ofs_q == OFS_STATUS) & ~hwdata[ST_OVR_BIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ho_q     <= 1'b1;
      wr_pend  <= 1'b0;
      ovr_seen <= 1'b0;
      ofs_q    <= 8'h00;
    end else begin
      ho_q    <= hreadyout;
      wr_pend <= take & hwrite;
      if (take) begin
        ofs_q <= haddr[7:0];
      end
      if (ovr_clr) begin
        ovr_seen <= 1'b0;
      end else if (st_rd & hrdata[ST_OVR_BIT]) begin
        ovr_seen <= 1'b1;
      end
    end
  end

  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  a_status_upper: assert property (st_rd |-> hrdata[31:5] == 27'h0)
    else $error("status upper bits set");
  a_data_upper: assert property (dat_rd |-> hrdata[31:9] == 23'h0)
    else $error("data upper bits set");
  a_empty_noerr: assert property (st_rd && !hrdata[ST_AVAIL_BIT] |-> hrdata[3:2] == 2'b00)
    else $error("error flag with empty buffer");
  a_ovr_sticky: assert property (st_rd && ovr_seen |-> hrdata[ST_OVR_BIT])
    else $error("overrun lost without clear");
  a_rdata_hold: assert property (!rd_end |-> $stable(hrdata))
    else $error("read data changed outside read");

  c_overrun: cover property (st_rd && hrdata[ST_OVR_BIT]);
  c_ninth: cover property (dat_rd && hrdata[8]);
  c_parity: cover property (st_rd && hrdata[ST_PARITY_ERROR_FLAG_BIT]);
  c_irq: cover property ($rose(irq));
endmodule

bind uart_rx_status uart_rx_status_asserts #(.RX_DEPTH(RX_DEPTH)) chk_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .rx_pin(rx_pin), .irq(irq));

// File: verification/serial_tx_model.sv
// Far-end serial transmitter driving the receive line.
// Assumes the receiver divisor yields bit_cycles clocks per bit.
`timescale 1ns/10ps
module serial_tx_model #(
  parameter int BIT_CYCLES = 16
) (
  input  wire logic clk,
  output logic      line
);
  // Clocks per bit; the bench raises it when it slows the receiver divisor
  int bit_cycles = BIT_CYCLES;

  initial line = 1'b1;

  // Bits after the start bit, LSB first; the last one is the stop bit
  task automatic send(input logic [10:0] bits, input int n);
    line <= 1'b0;
    repeat (bit_cycles) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      line <= bits[i];
      // A low stop is cut short so the idle line rejects any false start
      repeat ((i == n - 1 && !bits[i]) ? bit_cycles - 3 : bit_cycles) @(posedge clk);
    end
    line <= 1'b1;
    // One idle edge, so a following start never lands in the same time step
    @(posedge clk);
  endtask
endmodule

// File: verification/tb.sv
// Self-checking bench for the receive status and data readout block.
// Assumes divisor 0 (16 clocks a bit), except the last test at divisor 1.
`timescale 1ns/10ps
module tb;
  import uart_rx_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        rx_pin;
  logic        irq;
  logic [31:0] rdat;
  logic        pg;
  int          num_errors;
  int          cmp_count;

  uart_rx_status #(.RX_DEPTH(4)) uart_rx_status_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .rx_pin(rx_pin), .irq(irq));
  serial_tx_model #(.BIT_CYCLES(16)) serial_tx_model_i (.clk(hclk), .line(rx_pin));

  initial hclk = 1'b0;
  always #2 hclk = ~hclk;

  task automatic summarize();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One single AHB transfer; entered just after a rising edge
  task automatic bus(input logic [7:0] ofs, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
    htrans <= 2'h2;
    haddr  <= {24'h0, ofs};
    hwrite <= wr;
    hsize  <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
    bus(ofs, 1'b1, d, rdat);
  endtask

  task automatic rd_chk(input logic [7:0] ofs, input logic [31:0] exp, input string name);
    logic [31:0] v;
    bus(ofs, 1'b0, 32'h0, v);
    check(name, v, exp);
  endtask

  // Leaves room for the stop sample and a rejected false start to settle
  task automatic chr(input logic [10:0] bits, input int n);
    serial_tx_model_i.send(bits, n);
    repeat (20) @(posedge hclk);
  endtask

  initial begin
    repeat (10000) @(posedge hclk);
    num_errors++;
    summarize();
  end

  initial begin
    num_errors = 0;
    cmp_count = 0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    hresetn = 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(OFS_STATUS, 32'h10, "status reset");
    rd_chk(OFS_RXDATA, 32'h0, "data reset");
    wr(8'h20, 32'hFFFFFFFF);
    rd_chk(8'h20, 32'h0, "unmapped");
    wr(OFS_STATUS, 32'hFFFFFFFF);
    rd_chk(OFS_STATUS, 32'h10, "status protect");
    wr(OFS_BAUD, 32'h0);
    wr(OFS_CONFIG, 32'h1);
    wr(OFS_IRQ_ST, 32'hF);
    fork
      chr({1'b1, 8'hA5}, 9);
      begin
        repeat (80) @(posedge hclk);
        rd_chk(OFS_STATUS, 32'h0, "status busy");
      end
    join
    rd_chk(OFS_STATUS, 32'h11, "status avail");
    rd_chk(OFS_IRQ_ST, 32'h1, "irq status");
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(OFS_IRQ_MSK, 32'h1);
    rd_chk(OFS_IRQ_MSK, 32'h1, "irq mask");
    check("irq on", {31'h0, irq}, 32'h1);
    wr(OFS_IRQ_ST, 32'h1);
    rd_chk(OFS_RXDATA, 32'hA5, "data 8bit");
    check("irq off", {31'h0, irq}, 32'h0);
    rd_chk(OFS_STATUS, 32'h10, "status empty");
    wr(OFS_IRQ_MSK, 32'h0);
    // Even, odd, and the code that falls back to even
    for (int m = 0; m < 3; m++) begin
      pg = (^8'h5A) ^ (m == 1);
      wr(OFS_CONFIG, 32'h5 + 32'h4 * m);
      chr({1'b1, ~pg, 8'h5A}, 10);
      chr({1'b1, pg, 8'h5A}, 10);
      rd_chk(OFS_STATUS, 32'h19, "parity bad");
      rd_chk(OFS_RXDATA, 32'h5A, "data bad");
      rd_chk(OFS_STATUS, 32'h11, "parity good");
      rd_chk(OFS_RXDATA, 32'h5A, "data good");
    end
    wr(OFS_CONFIG, 32'h1);
    chr({1'b0, 8'hC3}, 9);
    rd_chk(OFS_STATUS, 32'h15, "framing");
    rd_chk(OFS_RXDATA, 32'hC3, "data framing");
    wr(OFS_CONFIG, 32'h3);
    chr({1'b1, 9'h1A5}, 10);
    rd_chk(OFS_RXDATA, 32'h1A5, "data 9bit");
    wr(OFS_CONFIG, 32'h1);
    for (int i = 0; i < 4; i++) serial_tx_model_i.send({3'b001, 8'h10 + i[7:0]}, 9);
    chr({1'b1, 8'h14}, 9);
    rd_chk(OFS_STATUS, 32'h13, "overrun");
    rd_chk(OFS_RXDATA, 32'h10, "oldest");
    wr(OFS_STATUS, 32'h2);
    rd_chk(OFS_STATUS, 32'h13, "overrun kept");
    wr(OFS_STATUS, 32'h0);
    rd_chk(OFS_STATUS, 32'h10, "overrun clear");
    rd_chk(OFS_RXDATA, 32'h0, "data flushed");
    chr({1'b1, 8'h3C}, 9);
    rd_chk(OFS_RXDATA, 32'h3C, "data after");
    // Divisor 1 doubles the bit time, so the baud tick is exercised
    wr(OFS_BAUD, 32'h1);
    serial_tx_model_i.bit_cycles = 32;
    chr({1'b1, 8'h96}, 9);
    rd_chk(OFS_STATUS, 32'h11, "status slow baud");
    rd_chk(OFS_RXDATA, 32'h96, "data slow baud");
    summarize();
  end
endmodule
